// ===== logic/chg_opt_regs.svh
`ifndef CHG_OPT_REGS_SVH
`define CHG_OPT_REGS_SVH

// Byte addresses on the register port; each 16-bit register is two bytes.
`define CHG_ADDR_MODE_LO      8'h34
`define CHG_ADDR_MODE_HI      8'h35
`define CHG_ADDR_HOT_LO       8'h36
`define CHG_ADDR_HOT_HI       8'h37

// Reset values.
`define CHG_MODE_RESET        16'h0000
`define CHG_HOT_RESET         16'h4a54
`define CHG_LIM_RESET_PCT     10'd150
`define CHG_UV_RESET_MV       13'd6000

// Field positions in the mode register.
`define CHG_B_HIGHZ           15
`define CHG_B_RESTORE         14
`define CHG_B_REMEASURE       13
`define CHG_B_REVERSE         12
`define CHG_B_OPTIMIZER       11
`define CHG_B_BATOFF          1
`define CHG_B_PMSEL           0

// Field positions in the hot alert register.
`define CHG_F_LIM             15:11
`define CHG_F_DEG             10:9
`define CHG_F_UV              7:6
`define CHG_B_EXTEND          5
`define CHG_F_WIDTH           4:3
`define CHG_B_CLEAR           2

// Clock rate and times in their own units.
`define CHG_CLK_MHZ           40
`define CHG_T_DEG0_US         15
`define CHG_T_DEG1_US         100
`define CHG_T_DEG2_US         400
`define CHG_T_DEG3_US         800
`define CHG_T_UV_US           20
`define CHG_T_WID0_US         100
`define CHG_T_WID1_MS         1
`define CHG_T_WID2_MS         10
`define CHG_T_WID3_MS         5

// Cycle counts derived from the times and the clock rate.
`define CHG_US_CYC(t)         ((t) * `CHG_CLK_MHZ)
`define CHG_MS_CYC(t)         ((t) * 1000 * `CHG_CLK_MHZ)

`endif

// ===== logic/chg_pkg.sv
package chg_pkg;

    // Processor hot output sequencer.
    typedef enum logic [1:0]
    {
        CHG_HOT_IDLE,
        CHG_HOT_PULSE,
        CHG_HOT_HOLD
    } chg_hot_state_t;

    typedef logic [18:0] chg_hot_cnt_t;
    typedef logic [15:0] chg_deg_cnt_t;

endpackage : chg_pkg

// ===== logic/chg_opt_regs.sv
// Summary of operation
// - High-impedance bit gives idle mode; above lockout regulator on, system fed from battery.
// - Restore bit reloads every register here to defaults, then clears itself.
// - Remeasure bit stops converter until measurement done, then self-clears.
// - Reverse supply only while its enable bit and the pin are both high.
// - Current optimizer runs only while its enable bit is set.
// - In idle mode battery switch on when bit is 0, off when 1.
// - In reverse supply the power monitor select bit picks its report.
// - Second limit code maps to percent, 5% steps then 50% steps.
// - The all-ones second limit code is ignored.
// - Critical current is 110% of the second limit.
// - Critical current must persist for selected deglitch before alert.
// - Undervoltage must persist for a fixed 20 us before alert.
// - Undervoltage code selects threshold for one cell or multi-cell packs.
// - With extension on, alert output stays low until host clears it.
// - Without extension each alert pulse lasts at least the selected width.
// - Writing 0 to pulse clear ends a held pulse; bit idles at 1.
`include "chg_opt_regs.svh"

module chg_opt_regs
    import chg_pkg::*;
#(
    parameter int unsigned DEG2_CYC = `CHG_US_CYC(`CHG_T_DEG2_US),
    parameter int unsigned DEG3_CYC = `CHG_US_CYC(`CHG_T_DEG3_US),
    parameter int unsigned WID1_CYC = `CHG_MS_CYC(`CHG_T_WID1_MS),
    parameter int unsigned WID2_CYC = `CHG_MS_CYC(`CHG_T_WID2_MS),
    parameter int unsigned WID3_CYC = `CHG_MS_CYC(`CHG_T_WID3_MS)
)
(
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Byte register port from the serial interface.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Supply and pin status.
    input  wire logic        vbus_above_lockout,
    input  wire logic        reverse_supply_pin,
    input  wire logic        cell_count_one,
    input  wire logic        floor_measure_done,
    // Comparator results from the analog front end.
    input  wire logic        over_second_limit,
    input  wire logic        over_critical_current,
    input  wire logic        sys_below_level,
    // Mode controls.
    output logic             highz_enable,
    output logic             internal_regulator_on,
    output logic             system_from_battery,
    output logic             restore_defaults,
    output logic             converter_disable,
    output logic             reverse_supply_active,
    output logic             optimizer_enable,
    output logic             battery_switch_on,
    output logic             power_monitor_reverse_select,
    // Alert thresholds.
    output logic      [9:0]  second_current_limit_pct,
    output logic      [12:0] critical_current_pct_x10,
    output logic      [12:0] system_undervoltage_mv,
    // Processor hot output, active low.
    output logic             processor_hot_alert_n
);

    logic [15:0]    mode_r;
    logic [15:0]    mode_nxt;
    logic [15:0]    hot_r;
    logic [15:0]    hot_nxt;
    logic [7:0]     rdata_r;
    logic [7:0]     rd_mux;
    logic [9:0]     lim_r;
    logic [9:0]     lim_pct;
    logic [12:0]    uv_r;
    logic [12:0]    uv_mv;
    logic [4:0]     lim_code;
    logic           lim_valid;
    logic           mode_wr_lo;
    logic           mode_wr_hi;
    logic           hot_wr_lo;
    logic           hot_wr_hi;
    logic [1:0]     dg_cond;
    logic [1:0]     dg_qual;
    chg_deg_cnt_t   dg_tgt [2];
    chg_deg_cnt_t   dg_cnt_r [2];
    logic           alert_event;
    chg_hot_state_t hot_st_r;
    chg_hot_state_t hot_st_nxt;
    chg_hot_cnt_t   hot_cnt_r;
    chg_hot_cnt_t   hot_cnt_nxt;
    chg_hot_cnt_t   wid_cyc;
    logic           hot_n_r;
    chg_hot_cnt_t   low_len_r;

    // Byte write strobes.
    assign mode_wr_lo = reg_wr && (reg_addr == `CHG_ADDR_MODE_LO);
    assign mode_wr_hi = reg_wr && (reg_addr == `CHG_ADDR_MODE_HI);
    assign hot_wr_lo  = reg_wr && (reg_addr == `CHG_ADDR_HOT_LO);
    assign hot_wr_hi  = reg_wr && (reg_addr == `CHG_ADDR_HOT_HI);

    // Read decode; unmapped addresses read as zero. Reserved bits are kept
    // as stored so they read back what was written.
    always_comb
    begin
        if (reg_addr == `CHG_ADDR_MODE_LO)
            rd_mux = mode_r[7:0];
        else if (reg_addr == `CHG_ADDR_MODE_HI)
            rd_mux = mode_r[15:8];
        else if (reg_addr == `CHG_ADDR_HOT_LO)
            rd_mux = hot_r[7:0];
        else if (reg_addr == `CHG_ADDR_HOT_HI)
            rd_mux = hot_r[15:8];
        else
            rd_mux = 8'h00;
    end

    // Next register contents. A pending restore overrides everything else,
    // so a write landing in the restore cycle is lost by design.
    always_comb
    begin
        mode_nxt = mode_r;
        hot_nxt  = hot_r;
        if (mode_wr_lo)
            mode_nxt[7:0] = reg_wdata;
        if (mode_wr_hi)
            mode_nxt[15:8] = reg_wdata; // Host write beats the done strobe.
        else if (floor_measure_done)
            mode_nxt[`CHG_B_REMEASURE] = 1'b0;
        if (hot_wr_lo)
            hot_nxt[7:0] = reg_wdata;
        else if (!hot_r[`CHG_B_CLEAR])
            hot_nxt[`CHG_B_CLEAR] = 1'b1;
        if (hot_wr_hi)
            hot_nxt[15:8] = reg_wdata;
        if (mode_r[`CHG_B_RESTORE])
        begin
            mode_nxt = `CHG_MODE_RESET;
            hot_nxt  = `CHG_HOT_RESET;
        end
    end

    // Register storage and read data.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_r  <= `CHG_MODE_RESET;
            hot_r   <= `CHG_HOT_RESET;
            rdata_r <= 8'h00;
        end
        else
        begin
            mode_r  <= mode_nxt;
            hot_r   <= hot_nxt;
            rdata_r <= reg_rd ? rd_mux : rdata_r;
        end
    end

    assign reg_rdata = rdata_r;

    // Mode controls, decoded straight from the stored bits and pins.
    assign highz_enable          = mode_r[`CHG_B_HIGHZ];
    assign internal_regulator_on = vbus_above_lockout;
    assign system_from_battery   = highz_enable && vbus_above_lockout;
    assign restore_defaults      = mode_r[`CHG_B_RESTORE];
    assign converter_disable     = mode_r[`CHG_B_REMEASURE];
    assign reverse_supply_active = mode_r[`CHG_B_REVERSE]
                                   && reverse_supply_pin;
    assign optimizer_enable      = mode_r[`CHG_B_OPTIMIZER];
    assign battery_switch_on     = !(highz_enable
                                     && mode_r[`CHG_B_BATOFF]);
    assign power_monitor_reverse_select = reverse_supply_active
                                          && mode_r[`CHG_B_PMSEL];

    // Second limit percentage. Code zero has no defined level, so it is
    // treated like the out-of-range code and the last level is kept.
    assign lim_code  = hot_r[`CHG_F_LIM];
    assign lim_valid = (lim_code != 5'h00) && (lim_code != 5'h1f);
    assign lim_pct   = (lim_code <= 5'h19)
                     ? 10'(10'd105 + 10'(lim_code) * 10'd5)
                     : 10'(10'd250 + 10'(lim_code - 5'h1a) * 10'd50);

    // Undervoltage level in millivolts, 250 mV per code step.
    assign uv_mv = (cell_count_one ? 13'd2850 : 13'd5750)
                 + 13'(hot_r[`CHG_F_UV]) * 13'd250;

    // Registered threshold outputs.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lim_r <= `CHG_LIM_RESET_PCT;
            uv_r  <= `CHG_UV_RESET_MV;
        end
        else
        begin
            lim_r <= lim_valid ? lim_pct : lim_r;
            uv_r  <= uv_mv;
        end
    end

    assign second_current_limit_pct = lim_r;
    assign critical_current_pct_x10 = 13'(lim_r) * 13'd11;
    assign system_undervoltage_mv   = uv_r;

    // Deglitch targets: channel 0 critical current, channel 1 undervoltage.
    assign dg_cond[0] = over_critical_current;
    assign dg_cond[1] = sys_below_level;
    assign dg_tgt[0]  = (hot_r[`CHG_F_DEG] == 2'b00)
                      ? 16'(`CHG_US_CYC(`CHG_T_DEG0_US))
                      : (hot_r[`CHG_F_DEG] == 2'b01)
                      ? 16'(`CHG_US_CYC(`CHG_T_DEG1_US))
                      : (hot_r[`CHG_F_DEG] == 2'b10)
                      ? 16'(DEG2_CYC) : 16'(DEG3_CYC);
    assign dg_tgt[1]  = 16'(`CHG_US_CYC(`CHG_T_UV_US));

    // A condition qualifies once it has held for the target number of
    // cycles; any single quiet cycle restarts the count.
    genvar g;
    for (g = 0; g < 2; g++)
    begin : g_dg
        always_ff @(posedge ref_clk or negedge resetn)
        begin
            if (!resetn)
                dg_cnt_r[g] <= 16'h0000;
            else if (!dg_cond[g])
                dg_cnt_r[g] <= 16'h0000;
            else if (!dg_qual[g])
                dg_cnt_r[g] <= dg_cnt_r[g] + 16'h0001;
        end

        assign dg_qual[g] = dg_cond[g]
                            && (dg_cnt_r[g] >= dg_tgt[g] - 16'h0001);

        property p_deglitch;
            @(posedge ref_clk) disable iff (!resetn)
            !dg_cond[g] |=> !dg_qual[g];
        endproperty
        a_deglitch: assert property (p_deglitch)
            else $error("Alert condition qualified without deglitch.");
    end

    assign alert_event = over_second_limit || dg_qual[0] || dg_qual[1];

    // Pulse width in cycles.
    assign wid_cyc = (hot_r[`CHG_F_WIDTH] == 2'b00)
                   ? 19'(`CHG_US_CYC(`CHG_T_WID0_US))
                   : (hot_r[`CHG_F_WIDTH] == 2'b01) ? 19'(WID1_CYC)
                   : (hot_r[`CHG_F_WIDTH] == 2'b10) ? 19'(WID2_CYC)
                   : 19'(WID3_CYC);

    // Hot output sequencer. A plain pulse stretches while the event stays,
    // so the width is a minimum, never a fixed length.
    always_comb
    begin
        hot_st_nxt  = hot_st_r;
        hot_cnt_nxt = hot_cnt_r;
        case (hot_st_r)
            CHG_HOT_IDLE:
                if (alert_event)
                begin
                    hot_cnt_nxt = 19'h00000;
                    hot_st_nxt  = hot_r[`CHG_B_EXTEND] ? CHG_HOT_HOLD
                                                      : CHG_HOT_PULSE;
                end
            CHG_HOT_PULSE:
                if (hot_r[`CHG_B_EXTEND])
                    hot_st_nxt = CHG_HOT_HOLD;
                else if (hot_cnt_r >= wid_cyc - 19'h00001)
                begin
                    if (!alert_event)
                        hot_st_nxt = CHG_HOT_IDLE;
                end
                else
                    hot_cnt_nxt = hot_cnt_r + 19'h00001;
            CHG_HOT_HOLD:
                if (!hot_r[`CHG_B_CLEAR])
                    hot_st_nxt = CHG_HOT_IDLE;
            default:
                hot_st_nxt = CHG_HOT_IDLE;
        endcase
    end

    // Sequencer state and registered active-low output.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hot_st_r  <= CHG_HOT_IDLE;
            hot_cnt_r <= 19'h00000;
            hot_n_r   <= 1'b1;
        end
        else
        begin
            hot_st_r  <= hot_st_nxt;
            hot_cnt_r <= hot_cnt_nxt;
            hot_n_r   <= (hot_st_nxt == CHG_HOT_IDLE);
        end
    end

    assign processor_hot_alert_n = hot_n_r;

    // Helper for checks: cycles the output has been low so far. It
    // saturates, so a pulse stretched for a long time never wraps back.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            low_len_r <= 19'h00000;
        else
            low_len_r <= hot_n_r ? 19'h00000
                       : (&low_len_r) ? low_len_r
                       : low_len_r + 19'h00001;
    end

    property p_highz;
        @(posedge ref_clk) disable iff (!resetn)
        (highz_enable && vbus_above_lockout)
            |-> (system_from_battery && internal_regulator_on);
    endproperty
    a_highz: assert property (p_highz)
        else $error("Idle mode not feeding system from battery.");

    property p_restore;
        @(posedge ref_clk) disable iff (!resetn)
        (mode_wr_hi && reg_wdata[6])
            |=> restore_defaults
            ##1 (mode_r == `CHG_MODE_RESET && hot_r == `CHG_HOT_RESET
                 && !restore_defaults);
    endproperty
    a_restore: assert property (p_restore)
        else $error("Restore did not reload defaults and clear itself.");

    property p_remeasure_hold;
        @(posedge ref_clk) disable iff (!resetn)
        (converter_disable && !floor_measure_done && !mode_wr_hi
         && !restore_defaults) |=> converter_disable;
    endproperty
    a_remeasure_hold: assert property (p_remeasure_hold)
        else $error("Converter restarted before measurement finished.");

    property p_remeasure_done;
        @(posedge ref_clk) disable iff (!resetn)
        (converter_disable && floor_measure_done && !mode_wr_hi)
            |=> !converter_disable;
    endproperty
    a_remeasure_done: assert property (p_remeasure_done)
        else $error("Remeasure bit did not self-clear.");

    property p_reverse;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(reverse_supply_active)
            |-> (reverse_supply_pin && $past(mode_nxt[`CHG_B_REVERSE]));
    endproperty
    a_reverse: assert property (p_reverse)
        else $error("Reverse supply entered without bit and pin.");

    property p_batoff;
        @(posedge ref_clk) disable iff (!resetn)
        (mode_wr_hi && reg_wdata[7] && !restore_defaults
         && mode_r[`CHG_B_BATOFF] && !mode_wr_lo) |=> !battery_switch_on;
    endproperty
    a_batoff: assert property (p_batoff)
        else $error("Battery switch left on in idle mode.");

    property p_ignore;
        @(posedge ref_clk) disable iff (!resetn)
        (hot_r[`CHG_F_LIM] == 5'h1f) |=> $stable(second_current_limit_pct);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("Out-of-range limit code changed the level.");

    property p_width;
        @(posedge ref_clk) disable iff (!resetn)
        ($rose(processor_hot_alert_n) && $past(hot_st_r) == CHG_HOT_PULSE
         && $stable(hot_r[`CHG_F_WIDTH]))
            |-> ($past(low_len_r) >= wid_cyc - 19'h00001);
    endproperty
    a_width: assert property (p_width)
        else $error("Hot pulse shorter than the selected width.");

    property p_hold;
        @(posedge ref_clk) disable iff (!resetn)
        (hot_st_r == CHG_HOT_HOLD && hot_r[`CHG_B_CLEAR])
            |=> !processor_hot_alert_n;
    endproperty
    a_hold: assert property (p_hold)
        else $error("Held hot output released without a clear.");

    property p_clear;
        @(posedge ref_clk) disable iff (!resetn)
        (hot_st_r == CHG_HOT_HOLD && !hot_r[`CHG_B_CLEAR])
            |=> (processor_hot_alert_n
                 ##1 (hot_r[`CHG_B_CLEAR] || $past(hot_wr_lo)));
    endproperty
    a_clear: assert property (p_clear)
        else $error("Pulse clear did not end the pulse and idle.");

endmodule : chg_opt_regs

// ===== tb/chg_front_model.sv
// Analog front end stand-in: ends a floor measurement after a fixed time.
module chg_front_model
#(
    parameter int unsigned MEAS_CYC = 10
)
(
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic resetn,
    // Measurement handshake.
    input  wire logic converter_disable,
    output logic      floor_measure_done
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned cnt_r;

    // Counts while the converter is held off, then pulses done once.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_r              <= 0;
            floor_measure_done <= 1'b0;
        end
        else
        begin
            cnt_r              <= converter_disable ? cnt_r + 1 : 0;
            floor_measure_done <= converter_disable && cnt_r == MEAS_CYC;
        end
    end
endmodule : chg_front_model

// ===== tb/chg_opt_regs_bench.sv
module chg_opt_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned WID2 = 100;
    logic        ref_clk, resetn, reg_wr, reg_rd, vbus, pin, one_cell;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic        done, over_lim, over_crit, sys_low;
    logic        highz, reg_on, sys_bat, restore, conv_off, rev_act, opt_en;
    logic        bsw_on, pm_sel, hot_n;
    logic [9:0]  lim_pct;
    logic [12:0] crit_x10, uv_mv;
    int          miscompares, comparisons, cyc, n;
    time         drop_t;

    chg_opt_regs #(.DEG2_CYC(20), .DEG3_CYC(40), .WID1_CYC(50),
        .WID2_CYC(WID2), .WID3_CYC(80)) chg_opt_regs_inst (
        .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .vbus_above_lockout(vbus),
        .reverse_supply_pin(pin), .cell_count_one(one_cell),
        .floor_measure_done(done), .over_second_limit(over_lim),
        .over_critical_current(over_crit), .sys_below_level(sys_low),
        .highz_enable(highz), .internal_regulator_on(reg_on),
        .system_from_battery(sys_bat), .restore_defaults(restore),
        .converter_disable(conv_off), .reverse_supply_active(rev_act),
        .optimizer_enable(opt_en), .battery_switch_on(bsw_on),
        .power_monitor_reverse_select(pm_sel),
        .second_current_limit_pct(lim_pct),
        .critical_current_pct_x10(crit_x10),
        .system_undervoltage_mv(uv_mv), .processor_hot_alert_n(hot_n));

    chg_front_model chg_front_model_inst (.ref_clk(ref_clk),
        .resetn(resetn), .converter_disable(conv_off),
        .floor_measure_done(done));

    // Clock at 40 MHz.
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Hang guard sized well above the expected run length.
    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            miscompares = miscompares + 1;
            final_report();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One byte write; strobe held across exactly one rising edge. A call
    // straight after another lets one edge pass so no strobe flips twice.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (drop_t == $time)
            @(negedge ref_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge ref_clk);
        reg_wr    = 1'b0;
        drop_t    = $time;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        if (drop_t == $time)
            @(negedge ref_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge ref_clk);
        reg_rd   = 1'b0;
        drop_t   = $time;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd

    // Waits for the alert output to return high, bounded.
    task automatic hot_idle();
        n = 0;
        while (hot_n !== 1'b1 && n < 1000)
        begin
            @(negedge ref_clk);
            n = n + 1;
        end
        chk({15'h0, hot_n}, 16'h0001);
    endtask : hot_idle

    // Holds a deglitched condition for a number of cycles.
    task automatic hold(input bit crit, input int cycles);
        if (crit)
            over_crit = 1'b1;
        else
            sys_low = 1'b1;
        repeat (cycles) @(negedge ref_clk);
        over_crit = 1'b0;
        sys_low   = 1'b0;
    endtask : hold

    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    localparam logic [4:0] LCODE[5] = '{5'h01, 5'h19, 5'h1a, 5'h1e, 5'h1f};
    localparam int         LPCT[5]  = '{110, 230, 250, 450, 450};
    localparam int         UVM[8]   = '{5750, 6000, 6250, 6500,
                                        2850, 3100, 3350, 3600};

    // Main sequence of register calls and checks.
    initial
    begin
        {resetn, reg_wr, reg_rd, pin, one_cell} = 5'h00;
        {over_lim, over_crit, sys_low} = 3'h0;
        {reg_addr, reg_wdata} = 16'h0000;
        vbus = 1'b1;
        miscompares = 0;
        comparisons = 0;
        cyc = 0;
        repeat (6) @(negedge ref_clk);
        resetn = 1'b1;
        rd(8'h34, 8'h00);
        rd(8'h35, 8'h00);
        rd(8'h36, 8'h54);
        rd(8'h37, 8'h4a);
        rd(8'h38, 8'h00);
        chk({6'h0, lim_pct}, 16'd150);
        chk({3'h0, uv_mv}, 16'd6000);
        chk({14'h0, hot_n, bsw_on}, 16'h0003);
        // Idle mode with the battery switch off, optimizer on. The switch
        // bit goes first, so entering idle mode is what turns it off.
        wr(8'h34, 8'h02);
        wr(8'h35, 8'h88);
        chk({12'h0, highz, reg_on, sys_bat, opt_en}, 16'h000f);
        chk({15'h0, bsw_on}, 16'h0000);
        // Below lockout the regulator is off and the system is not fed.
        vbus = 1'b0;
        @(negedge ref_clk);
        chk({14'h0, reg_on, sys_bat}, 16'h0000);
        vbus = 1'b1;
        wr(8'h35, 8'h10);
        chk({15'h0, bsw_on}, 16'h0001);
        chk({14'h0, rev_act, opt_en}, 16'h0000);
        wr(8'h34, 8'hfd);
        chk({14'h0, rev_act, pm_sel}, 16'h0000);
        pin = 1'b1;
        @(negedge ref_clk);
        chk({14'h0, rev_act, pm_sel}, 16'h0003);
        rd(8'h34, 8'hfd);
        // Floor remeasure ends on the front end's done pulse.
        wr(8'h35, 8'h20);
        chk({15'h0, conv_off}, 16'h0001);
        repeat (20) @(negedge ref_clk);
        chk({15'h0, conv_off}, 16'h0000);
        rd(8'h35, 8'h00);
        // Second limit codes, the all-ones code kept out.
        for (int i = 0; i < 5; i++)
        begin
            wr(8'h37, {LCODE[i], 3'b100});
            @(negedge ref_clk);
            chk({6'h0, lim_pct}, 16'(LPCT[i]));
            chk({3'h0, crit_x10}, 16'(LPCT[i] * 11));
        end
        // Undervoltage levels for multi-cell and one-cell packs.
        for (int i = 0; i < 8; i++)
        begin
            one_cell = i[2];
            wr(8'h36, {i[1:0], 6'h14});
            @(negedge ref_clk);
            chk({3'h0, uv_mv}, 16'(UVM[i]));
        end
        wr(8'h36, 8'h54);
        // Minimum pulse width with extension off.
        over_lim = 1'b1;
        @(negedge ref_clk);
        over_lim = 1'b0;
        n = 0;
        while (hot_n === 1'b0 && n < 500)
        begin
            @(negedge ref_clk);
            n = n + 1;
        end
        chk(16'(n), 16'(WID2));
        // Critical deglitch code 10: too short, then long enough.
        hold(1'b1, 15);
        repeat (5) @(negedge ref_clk);
        chk({15'h0, hot_n}, 16'h0001);
        hold(1'b1, 30);
        chk({15'h0, hot_n}, 16'h0000);
        hot_idle();
        hold(1'b0, 700);
        chk({15'h0, hot_n}, 16'h0001);
        // One quiet edge so the second hold restarts the count.
        @(negedge ref_clk);
        hold(1'b0, 900);
        chk({15'h0, hot_n}, 16'h0000);
        hot_idle();
        // Extension holds the alert until the host clears it.
        wr(8'h36, 8'h74);
        over_lim = 1'b1;
        @(negedge ref_clk);
        over_lim = 1'b0;
        repeat (2 * WID2) @(negedge ref_clk);
        chk({15'h0, hot_n}, 16'h0000);
        wr(8'h36, 8'h70);
        @(negedge ref_clk);
        chk({15'h0, hot_n}, 16'h0001);
        rd(8'h36, 8'h74);
        // Restore returns every register here to its defaults.
        wr(8'h35, 8'h40);
        chk({15'h0, restore}, 16'h0001);
        @(negedge ref_clk);
        rd(8'h35, 8'h00);
        rd(8'h34, 8'h00);
        rd(8'h36, 8'h54);
        rd(8'h37, 8'h4a);
        final_report();
    end
endmodule : chg_opt_regs_bench
